// [bififo_defines.svh]
// Constants for the level-flag and mailbox block of the two-way FIFO.
// Assumes a single shared clock for both ports.
`ifndef BIFIFO_DEFINES_SVH
`define BIFIFO_DEFINES_SVH

// Array geometry
`define WORD_W          36
`define COUNT_W         11
`define OFFSET_W        10
`define FIFO_DEPTH      11'h400

// Offset register indices on the select lines
`define OFS_FIFO1_EMPTY 2'h0
`define OFS_FIFO2_EMPTY 2'h1
`define OFS_FIFO1_FULL  2'h2
`define OFS_FIFO2_FULL  2'h3

// Reset values
`define OFFSET_PRESET   10'h008
`define MAIL_FLAG_RESET 1'b1

`endif

// [bififo_pkg.sv]
// Types shared by the level-flag and mailbox block.
// Assumes bififo_defines.svh is on the include path.
`include "bififo_defines.svh"

package bififo_pkg;

    // One port's bus request, sampled on the clock edge
    typedef struct packed {
        logic                  chip_select_n;
        logic                  direction;
        logic                  enable;
        logic                  mail_select;
        logic [`WORD_W-1:0]    bus;
    } port_req_t;

    // Data the block drives back onto a port
    typedef struct packed {
        logic [`WORD_W-1:0]    bus;
        logic                  bus_oe;
    } port_drive_t;

endpackage

// [bififo_level_flags_mailbox.sv]
// Almost-empty / almost-full flags, output-ready timing and the two
// mailbox bypass registers of a two-way FIFO. Both ports run on i_clk;
// the array and its pointers live outside and report word movements.
// How it works
// - Almost-empty flag is timed by the clock of the port reading that FIFO.
// - Almost-empty low at offset words or fewer, high from offset plus one.
// - Port B uses FIFO1 empty offset, port A uses FIFO2 empty offset.
// - A word in the output register no longer counts as stored.
// - Almost-empty rises on the second read-clock edge after the filling write.
// - First sync edge must trail the write by the second skew interval.
// - Almost-full flag is timed by the clock of the port writing that FIFO.
// - Almost-full low from depth minus offset words, high below that.
// - Port A uses FIFO1 full offset, port B uses FIFO2 full offset.
// - Almost-full rises on the second write-clock edge after the draining read.
// - First sync edge must trail the read by the second skew interval.
// - One 36-bit mailbox per direction, chosen by each port's mail select.
// - Selected port A write with mail select stores port A bus in A-to-B box.
// - Selected port B write with mail select stores port B bus in B-to-A box.
// - Writing a mailbox drops its flag; writes are ignored while it is low.
// - Enabled bus shows FIFO output register, or incoming mailbox if selected.
// - Port B mailbox read raises the A-to-B flag.
// - Port A mailbox read raises the B-to-A flag.
// - Reading a mailbox leaves its contents; only accepted writes change them.
// - Fall-through: output-ready and output load three read cycles after write.
// - On FIFO1 reset, fall-through drops port B ready one cycle earlier.
`include "bififo_defines.svh"

module bififo_level_flags_mailbox (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_b,
    // Port requests
    input  wire bififo_pkg::port_req_t   i_port_a,
    input  wire bififo_pkg::port_req_t   i_port_b,
    // Offset programming, qualified by a port A write
    input  wire logic                    i_offset_wr,
    input  wire logic [1:0]              i_offset_sel,
    // Mode strap
    input  wire logic                    i_fall_through_select,
    // Array side, index 0 is FIFO1 (A to B), index 1 is FIFO2
    input  wire logic [1:0]              i_fifo_reset,
    input  wire logic [1:0]              i_mem_wr,
    input  wire logic [1:0]              i_mem_shift,
    input  wire logic [`WORD_W-1:0]      i_fifo1_out_data,
    input  wire logic [`WORD_W-1:0]      i_fifo2_out_data,
    // Port drives
    output bififo_pkg::port_drive_t      o_port_a_drive,
    output bififo_pkg::port_drive_t      o_port_b_drive,
    // Level flags
    output logic                         o_port_a_almost_empty_flag,
    output logic                         o_port_b_almost_empty_flag,
    output logic                         o_port_a_almost_full_flag,
    output logic                         o_port_b_almost_full_flag,
    output logic                         o_port_a_empty_flag,
    output logic                         o_port_b_empty_flag,
    output logic [1:0]                   o_out_load,
    // Mailbox flags
    output logic                         o_a_to_b_mail_flag,
    output logic                         o_b_to_a_mail_flag
);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    logic                    act_a;
    logic                    act_b;
    logic                    wr_a;
    logic                    rd_a;
    logic                    wr_b;
    logic                    rd_b;
    logic                    ofs_wr;
    logic                    fall_through_select_meta;
    logic                    fall_through_select;
    logic [`OFFSET_W-1:0]    offset [4];
    logic [`COUNT_W-1:0]     count [2];
    logic [`COUNT_W-1:0]     next_count [2];
    logic [1:0]              ae_cmp;
    logic [1:0]              af_cmp;
    logic [1:0]              ae_s1;
    logic [1:0]              af_s1;
    logic [1:0]              ae;
    logic [1:0]              af;
    logic [1:0]              nonempty;
    logic [1:0]              rdy_s1;
    logic [1:0]              rdy_s2;
    logic [1:0]              rdy;
    logic [1:0]              next_rdy;
    logic [1:0]              mail_wr;
    logic [1:0]              mail_rd;
    logic [1:0]              mail_take;
    logic [1:0]              mail_flag;
    logic [`WORD_W-1:0]      mail_data [2];
    logic [`WORD_W-1:0]      mbox [2];

    // Port decode; port B direction is high for a read
    assign act_a = ~i_port_a.chip_select_n & i_port_a.enable;
    assign act_b = ~i_port_b.chip_select_n & i_port_b.enable;
    assign wr_a  = act_a & i_port_a.direction;
    assign rd_a  = act_a & ~i_port_a.direction;
    assign wr_b  = act_b & ~i_port_b.direction;
    assign rd_b  = act_b & i_port_b.direction;

    // Mailbox steering per direction
    assign mail_wr[0]   = wr_a & i_port_a.mail_select;
    assign mail_wr[1]   = wr_b & i_port_b.mail_select;
    assign mail_rd[0]   = rd_b & i_port_b.mail_select;
    assign mail_rd[1]   = rd_a & i_port_a.mail_select;
    assign mail_data[0] = i_port_a.bus;
    assign mail_data[1] = i_port_b.bus;
    assign mail_take    = mail_wr & mail_flag;

    // Offsets only load on a port A FIFO-side write cycle
    assign ofs_wr = i_offset_wr & wr_a & ~i_port_a.mail_select;

    // Strap is a static pin, so it is brought in through two stages
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fall_through_select_meta <= 1'b0;
            fall_through_select      <= 1'b0;
        end else begin
            fall_through_select_meta <= i_fall_through_select;
            fall_through_select      <= fall_through_select_meta;
        end
    end

    // Offset registers; each write stands alone, so gaps are harmless
    for (genvar j = 0; j < 4; j++) begin : g_offset
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                offset[j] <= `OFFSET_PRESET;
            end else if (i_fifo_reset[j%2]) begin
                offset[j] <= `OFFSET_PRESET;
            end else if (ofs_wr && i_offset_sel == 2'(j)) begin
                offset[j] <= i_port_a.bus[`OFFSET_W-1:0];
            end
        end
    end

    // Per-FIFO fill count, level compare and two-edge flag pipelines
    for (genvar i = 0; i < 2; i++) begin : g_fifo
        // Shift to the output register takes the word out of the count
        assign next_count[i] = count[i] + `COUNT_W'(i_mem_wr[i])
                               - `COUNT_W'(i_mem_shift[i]);
        assign ae_cmp[i]   = count[i] > {1'b0, offset[i]};
        assign af_cmp[i]   = count[i] < (`FIFO_DEPTH
                             - {1'b0, offset[2+i]});
        assign nonempty[i] = count[i] != '0;
        assign next_rdy[i] = nonempty[i] & rdy_s1[i]
                             & (~fall_through_select | rdy_s2[i]);

        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                count[i] <= '0;
            end else if (i_fifo_reset[i]) begin
                count[i] <= '0;
            end else begin
                count[i] <= next_count[i];
            end
        end

        // Falls on the first edge, rises only on the second
        // Shared clock: every edge already trails the event by a full
        // period, so the skew slip never arises here
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                ae_s1[i] <= 1'b0;
                ae[i]    <= 1'b0;
                af_s1[i] <= 1'b1;
                af[i]    <= 1'b1;
            end else begin
                ae_s1[i] <= ae_cmp[i];
                ae[i]    <= ae_cmp[i] & ae_s1[i];
                af_s1[i] <= af_cmp[i];
                af[i]    <= af_cmp[i] & af_s1[i];
            end
        end

        // Empty/ready: two edges standard, three in fall-through
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                rdy_s1[i]     <= 1'b0;
                rdy_s2[i]     <= 1'b0;
                rdy[i]        <= 1'b0;
                o_out_load[i] <= 1'b0;
            end else if (fall_through_select && i_fifo_reset[i]) begin
                rdy_s1[i]     <= 1'b0;
                rdy_s2[i]     <= 1'b0;
                rdy[i]        <= 1'b0;
                o_out_load[i] <= 1'b0;
            end else begin
                rdy_s1[i]     <= nonempty[i];
                rdy_s2[i]     <= nonempty[i] & rdy_s1[i];
                rdy[i]        <= next_rdy[i];
                o_out_load[i] <= fall_through_select & next_rdy[i] & ~rdy[i];
            end
        end

        // Mailbox: a new write beats a same-cycle read of the flag
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                mbox[i]      <= '0;
                mail_flag[i] <= `MAIL_FLAG_RESET;
            end else if (mail_take[i]) begin
                mbox[i]      <= mail_data[i];
                mail_flag[i] <= 1'b0;
            end else if (mail_rd[i]) begin
                mail_flag[i] <= 1'b1;
            end
        end

        a_ae_low_level: assert property (
            !ae_cmp[i] |=> !ae[i])
            else $error("almost-empty high at or below offset");
        a_ae_rise_delay: assert property (
            $rose(ae_cmp[i]) ##1 ae_cmp[i] |-> !ae[i] ##1 ae[i])
            else $error("almost-empty not raised on second edge");
        a_af_low_level: assert property (
            !af_cmp[i] |=> !af[i])
            else $error("almost-full high at depth minus offset");
        a_af_rise_delay: assert property (
            $rose(af_cmp[i]) ##1 af_cmp[i] |-> !af[i] ##1 af[i])
            else $error("almost-full not raised on second edge");
        a_mail_store: assert property (
            mail_wr[i] && mail_flag[i]
            |=> !mail_flag[i] && mbox[i] == $past(mail_data[i]))
            else $error("accepted mail write not stored");
        a_mail_ignore: assert property (
            !mail_flag[i] |=> mbox[i] == $past(mbox[i]))
            else $error("mailbox changed while flag low");
        a_mail_read_set: assert property (
            mail_rd[i] && !mail_take[i] |=> mail_flag[i])
            else $error("mailbox read did not raise flag");
        a_ready_fall_through_select_delay: assert property (
            fall_through_select && !i_fifo_reset[i] && !nonempty[i] ##1
            (nonempty[i] && fall_through_select && !i_fifo_reset[i])[*3]
            |=> !$past(rdy[i]) && rdy[i])
            else $error("fall-through ready not on third edge");
        a_reset_ready_drop: assert property (
            fall_through_select && i_fifo_reset[i] |=> !rdy[i])
            else $error("fall-through reset did not drop ready");

        c_mail_round_trip: cover property (
            mail_take[i] ##[1:20] mail_rd[i]);
        c_ae_rise: cover property ($rose(ae[i]));
        c_af_fall: cover property ($fell(af[i]));
        c_fall_through_select_load: cover property (o_out_load[i]);
    end

    // Read data: mailbox when selected, else the FIFO output register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_port_a_drive <= '0;
            o_port_b_drive <= '0;
        end else begin
            o_port_a_drive.bus    <= i_port_a.mail_select ? mbox[1]
                                     : i_fifo2_out_data;
            o_port_a_drive.bus_oe <= rd_a;
            o_port_b_drive.bus    <= i_port_b.mail_select ? mbox[0]
                                     : i_fifo1_out_data;
            o_port_b_drive.bus_oe <= rd_b;
        end
    end

    a_bus_mail_sel: assert property (
        rd_a && i_port_a.mail_select
        |=> o_port_a_drive.bus_oe && o_port_a_drive.bus == $past(mbox[1]))
        else $error("port A bus not showing mailbox");

    // Flag outputs, each straight from its flop
    assign o_port_b_almost_empty_flag = ae[0];
    assign o_port_a_almost_empty_flag = ae[1];
    assign o_port_a_almost_full_flag  = af[0];
    assign o_port_b_almost_full_flag  = af[1];
    assign o_port_b_empty_flag        = rdy[0];
    assign o_port_a_empty_flag        = rdy[1];
    assign o_a_to_b_mail_flag         = mail_flag[0];
    assign o_b_to_a_mail_flag         = mail_flag[1];

endmodule

// [bififo_array_model.sv]
// Array side of both FIFOs: word counts and output registers.
// Assumes the bench requests pushes and pops on the shared clock.
module bififo_array_model (
    // Clock, reset and bench commands
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic [1:0]  i_push,
    input  wire logic [1:0]  i_pop,
    input  wire logic [1:0]  i_clear,
    // Array movements seen by the block
    output logic [1:0]       o_mem_wr,
    output logic [1:0]       o_mem_shift,
    output logic [35:0]      o_out1,
    output logic [35:0]      o_out2
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] count [2];
    logic [35:0] out_q [2];

    assign o_out1 = out_q[0];
    assign o_out2 = out_q[1];

    // Full array refuses a push, empty one a shift
    for (genvar i = 0; i < 2; i++) begin : g_side
        assign o_mem_wr[i]    = i_push[i] & (count[i] != 11'h400);
        assign o_mem_shift[i] = i_pop[i] & (count[i] != 11'h000);
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                count[i] <= 11'h000;
                out_q[i] <= 36'h000000000;
            end else if (i_clear[i]) begin
                count[i] <= 11'h000;
            end else begin
                count[i] <= count[i] + 11'(o_mem_wr[i]) - 11'(o_mem_shift[i]);
                // Shifted word leaves memory for the output register
                if (o_mem_shift[i])
                    out_q[i] <= {25'h0, count[i]} ^ 36'h5a5a5a5a5;
            end
        end
    end
endmodule

// [tb_bififo_level_flags_mailbox.sv]
// Self-checking bench for the level flags and mailboxes.
// Assumes the array model stands in for both FIFO arrays.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_bififo_level_flags_mailbox;
    timeunit 1ns;
    timeprecision 100ps;
    logic                    i_clk, i_rst_b, ow, ft;
    logic [1:0]              sel, frst, push, pop, wr, sh, ld;
    logic [35:0]             o1, o2;
    logic                    aea, aeb, afa, afb, efa, efb, mab, port_a_mail_select;
    bififo_pkg::port_req_t   pa, pb;
    bififo_pkg::port_drive_t da, db;
    logic [9:0]              x, y;
    int seed = 59, n_mismatch = 0, n_tests = 0, cyc = 0;

    bififo_level_flags_mailbox dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_port_a(pa), .i_port_b(pb), .i_offset_wr(ow), .i_offset_sel(sel),
        .i_fall_through_select(ft), .i_fifo_reset(frst), .i_mem_wr(wr),
        .i_mem_shift(sh), .i_fifo1_out_data(o1), .i_fifo2_out_data(o2),
        .o_port_a_drive(da), .o_port_b_drive(db),
        .o_port_a_almost_empty_flag(aea), .o_port_b_almost_empty_flag(aeb),
        .o_port_a_almost_full_flag(afa), .o_port_b_almost_full_flag(afb),
        .o_port_a_empty_flag(efa), .o_port_b_empty_flag(efb),
        .o_out_load(ld), .o_a_to_b_mail_flag(mab), .o_b_to_a_mail_flag(port_a_mail_select));
    bififo_array_model u_array (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_push(push), .i_pop(pop), .i_clear(frst), .o_mem_wr(wr),
        .o_mem_shift(sh), .o_out1(o1), .o_out2(o2));

    // Clock and hang guard
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report;
        end
    end

    // Flag of each FIFO: index 0 is FIFO1, 1 is FIFO2
    function automatic logic ae(bit i); return i ? aea : aeb; endfunction
    function automatic logic af(bit i); return i ? afb : afa; endfunction
    function automatic logic ef(bit i); return i ? efa : efb; endfunction

    // Inputs change 1 ns after the edge
    task automatic tick; @(posedge i_clk); #1; endtask
    task automatic push_n(bit i, int n);
        push[i] = 1'b1; repeat (n) tick; push[i] = 1'b0;
    endtask
    task automatic pop1(bit i); pop[i] = 1'b1; tick; pop[i] = 1'b0; endtask
    task automatic clr(bit i); frst[i] = 1'b1; tick; frst[i] = 1'b0; endtask
    // One port cycle; port B read has direction high
    task automatic access(bit p, bit w, bit mb, logic [35:0] d);
        bififo_pkg::port_req_t r;
        r = '{chip_select_n: 1'b0, direction: w ^ p, enable: 1'b1,
              mail_select: mb, bus: d};
        if (p) pb = r; else pa = r;
        tick;
        pa.chip_select_n = 1'b1;
        pb.chip_select_n = 1'b1;
    endtask
    task automatic prog(logic [1:0] s, logic [9:0] v);
        sel = s; ow = 1'b1; access(1'b0, 1'b1, 1'b0, {26'h0, v}); ow = 1'b0;
    endtask
    // Count goes x, x+1, x: flag low, rises two edges late, falls
    task automatic ae_test(bit i, int x);
        push_n(i, x); tick; tick; `CHK(ae(i), 1'b0)
        push_n(i, 1); tick; `CHK(ae(i), 1'b0)
        tick; `CHK(ae(i), 1'b1)
        pop1(i); tick; `CHK(ae(i), 1'b0)
    endtask
    task automatic af_test(bit i, int c, int y);
        push_n(i, 1023 - y - c); tick; tick; `CHK(af(i), 1'b1)
        push_n(i, 1); tick; `CHK(af(i), 1'b0)
        pop1(i); tick; `CHK(af(i), 1'b0)
        tick; `CHK(af(i), 1'b1)
    endtask
    // Second write is refused; reads leave the word in place
    task automatic mail_test(bit p);
        logic [35:0] d1, d2;
        d1 = {4'($random(seed)), 32'($random(seed))};
        d2 = ~d1;
        access(p, 1'b1, 1'b1, d1);
        `CHK(p ? port_a_mail_select : mab, 1'b0)
        // A free edge between requests, so no strobe flips twice at once
        tick;
        access(p, 1'b1, 1'b1, d2);
        tick;
        access(!p, 1'b0, 1'b1, 36'h0);
        `CHK(p ? da.bus : db.bus, d1)
        `CHK(p ? da.bus_oe : db.bus_oe, 1'b1)
        `CHK(p ? port_a_mail_select : mab, 1'b1)
        tick;
        access(!p, 1'b0, 1'b1, 36'h0);
        `CHK(p ? da.bus : db.bus, d1)
        tick;
        access(!p, 1'b0, 1'b0, 36'h0);
        `CHK(p ? da.bus : db.bus, p ? o2 : o1)
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence, both FIFOs in turn
    initial begin
        {i_rst_b, ow, ft, sel, frst, push, pop} = '0;
        pa = '0; pb = '0;
        pa.chip_select_n = 1'b1;
        pb.chip_select_n = 1'b1;
        repeat (20) @(posedge i_clk);
        #1 i_rst_b = 1'b1;
        `CHK({mab, port_a_mail_select, aeb, afa, da.bus_oe}, 5'h1a)
        for (int i = 0; i < 2; i++) begin
            ft = !i[0];
            repeat (4) tick;
            push_n(i[0], 1);
            repeat (1 + ft) begin tick; `CHK(ef(i[0]), 1'b0) end
            tick; `CHK(ef(i[0]), 1'b1)
            `CHK(ld[i], ft)
            clr(i[0]); `CHK(ef(i[0]), !ft)
            tick; `CHK(ef(i[0]), 1'b0)
            ae_test(i[0], 8);
            af_test(i[0], 8, 8);
            clr(i[0]);
            x = 10'(1 + {$random(seed)} % 40);
            y = 10'(1 + {$random(seed)} % 40);
            // Offset writes with a random gap between them
            prog(2'(i), x);
            repeat (2 + {$random(seed)} % 5) tick;
            prog(2'(i + 2), y);
            ae_test(i[0], x);
            af_test(i[0], x, y);
            mail_test(i[0]);
            $display("side %0d done, x=%0d y=%0d", i, x, y);
        end
        final_report;
    end
endmodule
